// ===== hdl/ppc_regs.sv
// Two-port control register bank with byte register port
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_regs (
    input  wire logic            clk_i,
    input  wire logic            sys_rst_i,
    input  wire logic [7:0]      addr_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    input  wire logic [7:0]      wdata_i,
    output logic      [7:0]      rdata_o,
    output logic                 rvalid_o,
    input  wire logic            port1_negotiate_strap_i,
    input  wire logic            port2_negotiate_strap_i,
    input  wire logic            port1_speed_strap_i,
    input  wire logic            port2_speed_strap_i,
    input  wire logic            port1_duplex_strap_i,
    input  wire logic            port2_duplex_strap_i,
    input  wire logic [1:0]      an_failed_i,
    output logic      [1:0]      an_enable_o,
    output logic      [1:0]      speed_100_o,
    output logic      [1:0]      duplex_full_o,
    output logic      [9:0]      advertise_o,
    output logic      [1:0]      port_indicator_one_o,
    output logic      [1:0]      port_indicator_zero_o,
    output logic      [1:0]      tx_disable_o,
    output logic      [1:0]      an_restart_o,
    output logic      [1:0]      fef_enable_o,
    output logic      [1:0]      power_down_o,
    output logic      [1:0]      auto_xover_o,
    output logic      [1:0]      mdi_mode_o,
    output logic                 loop_p2_via_p1_o,
    output logic                 loop_p1_via_p2_o
);
    // =====================================================================
    // Address decode
    function automatic ppc_pkg::ppc_sel_t ppc_decode(input logic [7:0] a, input logic [7:0] neg_ofs,
                                                      input logic [7:0] line_ofs);
        ppc_decode = (a == neg_ofs) ? ppc_pkg::PPC_CFG_NEG :
                     (a == line_ofs) ? ppc_pkg::PPC_CFG_LINE : ppc_pkg::PPC_CFG_ANY;
    endfunction

    ppc_pkg::ppc_sel_t sel1;
    ppc_pkg::ppc_sel_t sel2;
    ppc_pkg::ppc_byte_t neg_q [2];
    ppc_pkg::ppc_byte_t line_q [2];
    logic [1:0] loop_w;
    logic [1:0] neg_wr;
    logic [1:0] line_wr;

    assign sel1       = ppc_decode(addr_i, `PPC_P1_NEG_OFS, `PPC_P1_LINE_OFS);
    assign sel2       = ppc_decode(addr_i, `PPC_P2_NEG_OFS, `PPC_P2_LINE_OFS);
    // Port 3 slots are reserved: writes dropped, reads zero
    assign neg_wr[0]  = wr_i && (sel1 == ppc_pkg::PPC_CFG_NEG);
    assign neg_wr[1]  = wr_i && (sel2 == ppc_pkg::PPC_CFG_NEG);
    assign line_wr[0] = wr_i && (sel1 == ppc_pkg::PPC_CFG_LINE);
    assign line_wr[1] = wr_i && (sel2 == ppc_pkg::PPC_CFG_LINE);

    // =====================================================================
    // Ports
    logic [1:0] neg_strap;
    logic [1:0] spd_strap;
    logic [1:0] dpx_strap;
    assign neg_strap = {port2_negotiate_strap_i, port1_negotiate_strap_i};
    assign spd_strap = {port2_speed_strap_i, port1_speed_strap_i};
    assign dpx_strap = {port2_duplex_strap_i, port1_duplex_strap_i};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_port
            ppc_port u_port (
                .clk_i            (clk_i),
                .sys_rst_i        (sys_rst_i),
                .neg_strap_i      (neg_strap[g]),
                .spd_strap_i      (spd_strap[g]),
                .dpx_strap_i      (dpx_strap[g]),
                .neg_wr_i         (neg_wr[g]),
                .line_wr_i        (line_wr[g]),
                .wdata_i          (wdata_i),
                .an_failed_i      (an_failed_i[g]),
                .neg_reg_o        (neg_q[g]),
                .line_reg_o       (line_q[g]),
                .an_enable_o      (an_enable_o[g]),
                .speed_100_o      (speed_100_o[g]),
                .duplex_full_o    (duplex_full_o[g]),
                .advertise_o      (advertise_o[g*5 +: 5]),
                .indicator_one_o  (port_indicator_one_o[g]),
                .indicator_zero_o (port_indicator_zero_o[g]),
                .tx_disable_o     (tx_disable_o[g]),
                .an_restart_o     (an_restart_o[g]),
                .fef_enable_o     (fef_enable_o[g]),
                .power_down_o     (power_down_o[g]),
                .auto_xover_o     (auto_xover_o[g]),
                .mdi_mode_o       (mdi_mode_o[g]),
                .loopback_o       (loop_w[g])
            );
        end
    endgenerate

    // Loop is named by the port whose line is looped, not the port whose PMA turns it round
    assign loop_p2_via_p1_o = loop_w[0];
    assign loop_p1_via_p2_o = loop_w[1];

    // =====================================================================
    // Read path, one cycle latency
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i) begin
                case (1'b1)
                    (sel1 == ppc_pkg::PPC_CFG_NEG):  rdata_o <= neg_q[0];
                    (sel1 == ppc_pkg::PPC_CFG_LINE): rdata_o <= line_q[0];
                    (sel2 == ppc_pkg::PPC_CFG_NEG):  rdata_o <= neg_q[1];
                    (sel2 == ppc_pkg::PPC_CFG_LINE): rdata_o <= line_q[1];
                    default:                         rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule

// ===== hdl/ppc_cfg.svh
// Offsets, field positions, reset values and the rule summary for the port control bank
// =====================================================================
// Summary of operation
// - Negotiation enable set: negotiate speed/duplex; clear: use forced speed and duplex bits.
// - Negotiation enable, speed and duplex defaults come from straps sampled during reset; the code catches them on the first clock edge after reset release.
// - Negotiation off: forced speed one selects 100BT, zero selects 10BT.
// - Forced duplex one is full, zero half; used when negotiation off or failed.
// - Bits 4..0 advertise pause, 100 full, 100 half, 10 full, 10 half; default one.
// - LED-off bit drives both indicator outputs of the port high.
// - Transmit-disable bit one disables the port transmitter.
// - Far-end fault disable stops fault detection and fault pattern transmission.
// - Bit 2 one disables automatic crossover; zero enables it.
// - Crossover off: bit 1 one forces MDI, zero forces MDI-X.
// - Port 1 loopback: port 2 receive looped through port 1 back to port 2 transmit.
// - Port 2 loopback: port 1 receive looped through port 2 back to port 1 transmit.
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// =====================================================================
// Register offsets
`define PPC_P1_NEG_OFS     8'h1C
`define PPC_P1_LINE_OFS    8'h1D
`define PPC_P2_NEG_OFS     8'h2C
`define PPC_P2_LINE_OFS    8'h2D
`define PPC_P3_RSVD_A_OFS  8'h3C
`define PPC_P3_RSVD_B_OFS  8'h3D

// =====================================================================
// Negotiation control fields
`define PPC_NEG_EN_BIT     7
`define PPC_NEG_SPD_BIT    6
`define PPC_NEG_DPX_BIT    5
`define PPC_ADV_MSB        4
`define PPC_ADV_RST        5'h1F

// =====================================================================
// Line control fields
`define PPC_LED_OFF_BIT    7
`define PPC_TX_DIS_BIT     6
`define PPC_RESTART_BIT    5
`define PPC_FEF_DIS_BIT    4
`define PPC_PWR_DN_BIT     3
`define PPC_XOVR_DIS_BIT   2
`define PPC_FORCE_MDI_BIT  1
`define PPC_LOOP_BIT       0
`define PPC_LINE_RST       8'h00

`endif

// ===== hdl/ppc_pkg.sv
// Types shared by the port control bank
package ppc_pkg;
    typedef logic [7:0] ppc_byte_t;
    typedef enum logic [1:0] {
        PPC_CFG_ANY,
        PPC_CFG_NEG,
        PPC_CFG_LINE
    } ppc_sel_t;
endpackage

// ===== hdl/ppc_port.sv
// One copper port: control registers and the derived PHY controls
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_port (
    input  wire logic            clk_i,
    input  wire logic            sys_rst_i,
    input  wire logic            neg_strap_i,
    input  wire logic            spd_strap_i,
    input  wire logic            dpx_strap_i,
    input  wire logic            neg_wr_i,
    input  wire logic            line_wr_i,
    input  wire logic [7:0]      wdata_i,
    input  wire logic            an_failed_i,
    output logic      [7:0]      neg_reg_o,
    output logic      [7:0]      line_reg_o,
    output logic                 an_enable_o,
    output logic                 speed_100_o,
    output logic                 duplex_full_o,
    output logic      [4:0]      advertise_o,
    output logic                 indicator_one_o,
    output logic                 indicator_zero_o,
    output logic                 tx_disable_o,
    output logic                 an_restart_o,
    output logic                 fef_enable_o,
    output logic                 power_down_o,
    output logic                 auto_xover_o,
    output logic                 mdi_mode_o,
    output logic                 loopback_o
);
    // =====================================================================
    // Storage
    logic [7:0] neg_reg;
    logic [7:0] line_reg;
    logic       strap_done_reg;
    logic       restart_reg;

    // Async reset may only load constants, so the straps are caught on the first edge after release
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            neg_reg        <= {3'h7, `PPC_ADV_RST};
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            neg_reg        <= {neg_strap_i, spd_strap_i, dpx_strap_i, neg_reg[`PPC_ADV_MSB:0]};
            strap_done_reg <= 1'b1;
        end else if (neg_wr_i) begin
            neg_reg        <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_reg <= `PPC_LINE_RST;
        end else if (line_wr_i) begin
            line_reg <= wdata_i;
        end
    end

    // Restart is a one-cycle pulse per write of one; the stored bit reads back as written
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= line_wr_i & wdata_i[`PPC_RESTART_BIT];
        end
    end

    // =====================================================================
    // Derived controls, all registered
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            an_enable_o   <= 1'b1;
            speed_100_o   <= 1'b1;
            duplex_full_o <= 1'b1;
            advertise_o   <= `PPC_ADV_RST;
        end else begin
            an_enable_o   <= neg_reg[`PPC_NEG_EN_BIT];
            // While negotiating the speed comes from the exchange, so the forced value is advertised only
            speed_100_o   <= neg_reg[`PPC_NEG_SPD_BIT];
            duplex_full_o <= (!neg_reg[`PPC_NEG_EN_BIT] || an_failed_i) ? neg_reg[`PPC_NEG_DPX_BIT] : 1'b0;
            advertise_o   <= neg_reg[`PPC_ADV_MSB:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            indicator_one_o  <= 1'b0;
            indicator_zero_o <= 1'b0;
            tx_disable_o     <= 1'b0;
            an_restart_o     <= 1'b0;
            fef_enable_o     <= 1'b1;
            power_down_o     <= 1'b0;
            auto_xover_o     <= 1'b1;
            mdi_mode_o       <= 1'b0;
            loopback_o       <= 1'b0;
        end else begin
            indicator_one_o  <= line_reg[`PPC_LED_OFF_BIT];
            indicator_zero_o <= line_reg[`PPC_LED_OFF_BIT];
            tx_disable_o     <= line_reg[`PPC_TX_DIS_BIT];
            an_restart_o     <= restart_reg;
            fef_enable_o     <= !line_reg[`PPC_FEF_DIS_BIT];
            power_down_o     <= line_reg[`PPC_PWR_DN_BIT];
            auto_xover_o     <= !line_reg[`PPC_XOVR_DIS_BIT];
            mdi_mode_o       <= line_reg[`PPC_FORCE_MDI_BIT];
            loopback_o       <= line_reg[`PPC_LOOP_BIT];
        end
    end

    assign neg_reg_o  = neg_reg;
    assign line_reg_o = line_reg;
endmodule

// ===== verification/ppc_regs_assertions.sv
// Concurrent checks on the port control bank outputs
`timescale 1ns/1ps
module ppc_regs_chk (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic       wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [9:0] advertise_o,
    input wire logic [1:0] speed_100_o,
    input wire logic [1:0] port_indicator_one_o,
    input wire logic [1:0] port_indicator_zero_o,
    input wire logic [1:0] tx_disable_o,
    input wire logic [1:0] an_restart_o,
    input wire logic [1:0] fef_enable_o,
    input wire logic [1:0] auto_xover_o,
    input wire logic       loop_p1_via_p2_o
);
    // =====================================================================
    // Write decodes; controls settle one edge after the write edge
    wire neg1_wr  = wr_i && addr_i == 8'h1C;
    wire neg2_wr  = wr_i && addr_i == 8'h2C;
    wire line1_wr = wr_i && addr_i == 8'h1D;
    wire line2_wr = wr_i && addr_i == 8'h2D;
    wire rst1_wr  = line1_wr && wdata_i[5];
    wire rst2_wr  = line2_wr && wdata_i[5];
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // =====================================================================
    // Properties
    adv_follows_a: assert property (neg1_wr |-> ##2 advertise_o[4:0] == $past(wdata_i[4:0], 2))
        else $error("advertise field not applied");
    speed_follows_a: assert property (neg2_wr |-> ##2 speed_100_o[1] == $past(wdata_i[6], 2))
        else $error("forced speed not applied");
    led_off_a: assert property (line1_wr |-> ##2 port_indicator_one_o[0] == $past(wdata_i[7], 2)
        && port_indicator_zero_o[0] == port_indicator_one_o[0]) else $error("indicator blanking wrong");
    tx_disable_a: assert property (line1_wr |-> ##2 tx_disable_o[0] == $past(wdata_i[6], 2))
        else $error("transmit disable wrong");
    restart_pulse_a: assert property (an_restart_o[0] == $past(rst1_wr, 2))
        else $error("restart pulse on port one wrong");
    restart_two_a: assert property (rst2_wr |-> ##2 an_restart_o[1])
        else $error("restart pulse on port two missing");
    fault_enable_a: assert property (line2_wr |-> ##2 fef_enable_o[1] == !$past(wdata_i[4], 2))
        else $error("far-end fault enable wrong");
    xover_off_a: assert property (line2_wr |-> ##2 auto_xover_o[1] != $past(wdata_i[2], 2))
        else $error("crossover enable wrong");
    loop_two_a: assert property (line2_wr |-> ##2 loop_p1_via_p2_o == $past(wdata_i[0], 2))
        else $error("port two loopback wrong");
endmodule

bind ppc_regs ppc_regs_chk ppc_regs_chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .advertise_o(advertise_o), .speed_100_o(speed_100_o),
    .port_indicator_one_o(port_indicator_one_o), .port_indicator_zero_o(port_indicator_zero_o),
    .tx_disable_o(tx_disable_o), .an_restart_o(an_restart_o), .fef_enable_o(fef_enable_o),
    .auto_xover_o(auto_xover_o), .loop_p1_via_p2_o(loop_p1_via_p2_o));

// ===== verification/ppc_link_partner.sv
// Behavioural cable partner: answers a restarted negotiation after a delay
`timescale 1ns/1ps
module ppc_link_partner #(
    parameter int DLY = 20
) (
    input  wire logic       clk_i,
    input  wire logic       an_enable_i,
    input  wire logic       an_restart_i,
    input  wire logic [4:0] advertise_i,
    input  wire logic [3:0] caps_i,
    output logic            an_failed_o
);
    int cnt = 0;
    initial an_failed_o = 1'b0;
    // Fails when no speed/duplex ability is shared; result only moves after a restart
    always @(posedge clk_i) begin
        if (an_restart_i) cnt <= DLY;
        else if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 1) an_failed_o <= an_enable_i && (advertise_i[3:0] & caps_i) == 4'h0;
    end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the port control bank
`timescale 1ns/1ps
module testbench;
    logic       clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, rvalid_o, lp2, lp1;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, neg [2], line [2];
    logic [5:0] strap = 6'h00;
    logic [3:0] caps [2] = '{4'h0, 4'h0};
    logic [1:0] an_en, spd, dpx, ind1, ind0, txd, rst, fef, pwr, xov, mdi;
    // One partner model drives each bit, so this is a net rather than a variable
    wire  [1:0] an_failed_i;
    logic [9:0] adv;
    logic [7:0] ra [7] = '{8'h1C, 8'h1D, 8'h2C, 8'h2D, 8'h3C, 8'h3D, 8'h1E};
    int         n_mismatch = 0, total_checks = 0, cyc = 0;
    initial forever #25 clk_i = ~clk_i;
    ppc_regs ppc_regs_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .port1_negotiate_strap_i(strap[2]),
        .port1_speed_strap_i(strap[1]), .port1_duplex_strap_i(strap[0]), .port2_negotiate_strap_i(strap[5]),
        .port2_speed_strap_i(strap[4]), .port2_duplex_strap_i(strap[3]), .an_failed_i(an_failed_i),
        .an_enable_o(an_en), .speed_100_o(spd), .duplex_full_o(dpx), .advertise_o(adv),
        .port_indicator_one_o(ind1), .port_indicator_zero_o(ind0), .tx_disable_o(txd), .an_restart_o(rst),
        .fef_enable_o(fef), .power_down_o(pwr), .auto_xover_o(xov), .mdi_mode_o(mdi),
        .loop_p2_via_p1_o(lp2), .loop_p1_via_p2_o(lp1));
    for (genvar p = 0; p < 2; p++) begin : g_lp
        ppc_link_partner ppc_link_partner_i (.clk_i(clk_i), .an_enable_i(an_en[p]), .an_restart_i(rst[p]),
            .advertise_i(adv[p*5+:5]), .caps_i(caps[p]), .an_failed_o(an_failed_i[p]));
    end
    // =====================================================================
    // Helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] exp_reg(logic [7:0] a);
        if (a[7:4] inside {4'h1, 4'h2} && a[3:1] == 3'b110) return a[0] ? line[a[5]] : neg[a[5]];
        return 8'h00;
    endfunction
    task automatic outs();
        for (int p = 0; p < 2; p++) begin
            chk("an_enable", neg[p][7], an_en[p]);
            chk("speed", neg[p][6], spd[p]);
            chk("duplex", neg[p][5] & (!neg[p][7] | an_failed_i[p]), dpx[p]);
            chk("advertise", neg[p][4:0], adv[p*5+:5]);
            chk("indicators", {2{line[p][7]}}, {ind1[p], ind0[p]});
            chk("tx_disable", line[p][6], txd[p]);
            chk("fef_enable", !line[p][4], fef[p]);
            chk("power_down", line[p][3], pwr[p]);
            chk("auto_xover", !line[p][2], xov[p]);
            chk("mdi_mode", line[p][1], mdi[p]);
        end
        chk("loopback", {line[1][0], line[0][0]}, {lp1, lp2});
    endtask
    task automatic rd(logic [7:0] a);
        @(negedge clk_i);
        addr_i = a;
        rd_i = 1;
        @(negedge clk_i);
        rd_i = 0;
        chk("rvalid", 1, rvalid_o);
        chk("rdata", exp_reg(a), rdata_o);
    endtask
    // Writes, then looks at the restart pulse and the controls in the cycle they settle
    task automatic wr_chk(logic [7:0] a, logic [7:0] d);
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1;
        @(negedge clk_i);
        wr_i = 0;
        if (exp_reg(a) !== 8'h00 || a[3:1] == 3'b110 && a[7:4] inside {4'h1, 4'h2})
            if (a[0]) line[a[5]] = d;
            else neg[a[5]] = d;
        @(negedge clk_i);
        chk("restart", {a == 8'h2D && d[5], a == 8'h1D && d[5]}, rst);
        outs();
        @(negedge clk_i);
        chk("restart_end", 0, rst);
    endtask
    // Straps are caught on the first edge after reset release; the model takes them as defaults
    task automatic rst_dut(logic [5:0] s);
        strap = s;
        sys_rst_i = 1;
        repeat (8) @(negedge clk_i);
        sys_rst_i = 0;
        repeat (3) @(negedge clk_i);
        for (int p = 0; p < 2; p++) begin
            neg[p] = {s[p*3+:3], 5'h1F};
            line[p] = 8'h00;
        end
        outs();
        foreach (ra[i]) rd(ra[i]);
    endtask
    // =====================================================================
    // Sequence
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'h310B8AFF));
        rst_dut(6'($urandom));
        repeat (60) begin
            addr_i = ra[$urandom_range(6, 0)];
            wr_chk(addr_i, 8'($urandom) & 8'hDF);
            rd(addr_i);
        end
        caps[1] = 4'hF;
        wr_chk(8'h1C, 8'hE0);
        wr_chk(8'h1D, 8'h20);
        wr_chk(8'h2C, 8'hFF);
        wr_chk(8'h2D, 8'h24);
        repeat (30) @(negedge clk_i);
        outs();
        wr_chk(8'h1C, 8'hC0);
        rst_dut(~strap);
        conclude();
    end
endmodule
